// *** rtl/rxdsc_regs.svh ***
`ifndef RXDSC_REGS_SVH
`define RXDSC_REGS_SVH
// Register word indices (printed offsets); byte address is four times the index
`define RXDSC_IDX_DEMOD 8'h19
`define RXDSC_IDX_SYNCMIN 8'h1a
`define RXDSC_IDX_PRESCALER 8'h30
`define RXDSC_IDX_STATUS 8'h31
`define RXDSC_RST_DEMOD 8'h4d
`define RXDSC_RST_SYNCMIN 8'h00
`define RXDSC_RST_PRESCALER 12'h000
// Demodulator settings fields
`define RXDSC_CH_USE_MSB 7
`define RXDSC_CH_USE_LSB 6
`define RXDSC_FIXED_BIT 5
`define RXDSC_EVEN_BIT 4
`define RXDSC_TAU_RCV_MSB 3
`define RXDSC_TAU_RCV_LSB 2
`define RXDSC_TAU_BURST_MSB 1
`define RXDSC_TAU_BURST_LSB 0
// Sync and minimum length fields
`define RXDSC_SYNC_LEN_MSB 7
`define RXDSC_SYNC_LEN_LSB 6
`define RXDSC_MIN_LEN_MSB 5
`define RXDSC_MIN_LEN_LSB 0
`define RXDSC_MIN_LEN_SCALE 3'h4
`define RXDSC_SYNC_HI 8'hb2
`define RXDSC_SYNC_LO 8'h4d
`endif

// *** rtl/rxdsc_pkg.sv ***
package rxdsc_pkg;
  typedef enum logic [1:0] {
    RXDSC_CH_STRONGER = 2'h0,
    RXDSC_CH_STRONGER_HOLD = 2'h1,
    RXDSC_CH_COMBINE = 2'h2,
    RXDSC_CH_RESERVED = 2'h3
  } rxdsc_ch_use_t;
  typedef enum logic [3:0] {
    RXDSC_PK_IDLE = 4'h1,
    RXDSC_PK_COUNT = 4'h2,
    RXDSC_PK_DONE = 4'h4,
    RXDSC_PK_DROP = 4'h8
  } rxdsc_pk_state_t;
endpackage : rxdsc_pkg

// *** rtl/rxdsc_tick_div.sv ***
`timescale 1ns/1ps
`default_nettype none
module rxdsc_tick_div
  import rxdsc_pkg::*;
#(
  parameter int PW = 12
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ref_tick,
  input wire logic [PW-1:0] i_prescaler_value,
  input wire logic i_even,
  output logic o_tick
);
  logic [PW+1:0] cnt;
  logic [PW+1:0] last;
  // Divisor is 2P+1 (odd) or 2P+2 (even)
  assign last = {1'b0, i_prescaler_value, 1'b0} + {{(PW+1){1'b0}}, i_even};
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt <= '0;
      o_tick <= 1'b0;
    end
    else if (i_ref_tick)
    begin
      if (cnt >= last)
      begin
        cnt <= '0;
        o_tick <= 1'b1;
      end
      else
      begin
        cnt <= cnt + 1'b1;
        o_tick <= 1'b0;
      end
    end
    else
    begin
      o_tick <= 1'b0;
    end
  end
endmodule : rxdsc_tick_div
`default_nettype wire

// *** rtl/rxdsc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rxdsc_regs.svh"
module rxdsc_top
  import rxdsc_pkg::*;
#(
  parameter int PW = 12,
  parameter int LW = 9
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_sync_detect_enable,
  input wire logic i_rate_106k,
  input wire logic i_ref_tick,
  input wire logic i_rx_active,
  input wire logic i_rx_burst,
  input wire logic i_i_stronger,
  input wire logic i_pkt_start,
  input wire logic i_pkt_byte,
  input wire logic i_pkt_end,
  output logic o_use_i,
  output logic o_use_q,
  output logic o_pll_freeze,
  output logic [1:0] o_pll_tau,
  output logic o_timer_tick,
  output logic [7:0] o_sync_byte,
  output logic o_pkt_accept,
  output logic o_pkt_drop
);
  logic [7:0] demodulator_settings;
  logic [7:0] sync_and_min_length;
  logic [PW-1:0] prescaler_value;
  logic bus_done;
  logic held_valid;
  logic held_i;
  logic [LW-1:0] pkt_len;
  logic [7:0] accepted_cnt;
  logic [7:0] dropped_cnt;
  logic tick;
  logic [2:0] sync_pos;
  logic [2:0] sync_total;
  rxdsc_pk_state_t pk_state;
  rxdsc_pk_state_t next_pk_state;
  logic [1:0] channel_use_select;
  logic fixed_channel_enable;
  logic prescaler_even_select;
  logic [1:0] pll_receive_time_constant;
  logic [1:0] pll_burst_time_constant;
  logic [1:0] sync_prefix_length;
  logic [5:0] min_packet_length;
  logic len_ok;
  logic wr_hit;
  logic rd_hit;

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    merge_byte = be[0] ? wd[7:0] : old;
  endfunction : merge_byte

  assign channel_use_select = demodulator_settings[`RXDSC_CH_USE_MSB:`RXDSC_CH_USE_LSB];
  assign fixed_channel_enable = demodulator_settings[`RXDSC_FIXED_BIT];
  assign prescaler_even_select = demodulator_settings[`RXDSC_EVEN_BIT];
  assign pll_receive_time_constant =
    demodulator_settings[`RXDSC_TAU_RCV_MSB:`RXDSC_TAU_RCV_LSB];
  assign pll_burst_time_constant =
    demodulator_settings[`RXDSC_TAU_BURST_MSB:`RXDSC_TAU_BURST_LSB];
  assign sync_prefix_length = sync_and_min_length[`RXDSC_SYNC_LEN_MSB:`RXDSC_SYNC_LEN_LSB];
  assign min_packet_length = sync_and_min_length[`RXDSC_MIN_LEN_MSB:`RXDSC_MIN_LEN_LSB];

  // One wait cycle per access keeps read data registered
  assign wr_hit = i_avs_write && !bus_done;
  assign rd_hit = i_avs_read && !bus_done;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bus_done <= 1'b0;
      o_avs_waitrequest <= 1'b1;
    end
    else
    begin
      bus_done <= (i_avs_read || i_avs_write) && !bus_done;
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !bus_done);
    end
  end

  // Writes land on the cycle before waitrequest drops, once per access
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      demodulator_settings <= `RXDSC_RST_DEMOD;
      sync_and_min_length <= `RXDSC_RST_SYNCMIN;
      prescaler_value <= `RXDSC_RST_PRESCALER;
    end
    else if (wr_hit)
    begin
      if (i_avs_address == `RXDSC_IDX_DEMOD)
      begin
        demodulator_settings <= merge_byte(demodulator_settings, i_avs_writedata,
                                           i_avs_byteenable);
      end
      if (i_avs_address == `RXDSC_IDX_SYNCMIN)
      begin
        sync_and_min_length <= merge_byte(sync_and_min_length, i_avs_writedata,
                                          i_avs_byteenable);
      end
      if (i_avs_address == `RXDSC_IDX_PRESCALER)
      begin
        if (i_avs_byteenable[0])
        begin
          prescaler_value[7:0] <= i_avs_writedata[7:0];
        end
        if (i_avs_byteenable[1])
        begin
          prescaler_value[PW-1:8] <= i_avs_writedata[PW-1:8];
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_avs_readdata <= '0;
    end
    else if (rd_hit)
    begin
      unique case (i_avs_address)
        `RXDSC_IDX_DEMOD: o_avs_readdata <= {24'h000000, demodulator_settings};
        `RXDSC_IDX_SYNCMIN: o_avs_readdata <= {24'h000000, sync_and_min_length};
        `RXDSC_IDX_PRESCALER: o_avs_readdata <= {{(32-PW){1'b0}}, prescaler_value};
        `RXDSC_IDX_STATUS: o_avs_readdata <= {8'h00, dropped_cnt, accepted_cnt,
                                             6'h00, held_valid, held_i};
        default: o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // Stronger-channel choice, held for the rest of the reception in code 01
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      held_valid <= 1'b0;
      held_i <= 1'b1;
    end
    else if (!i_rx_active)
    begin
      held_valid <= 1'b0;
    end
    else if (!held_valid)
    begin
      held_valid <= 1'b1;
      held_i <= i_i_stronger;
    end
  end

  // Code 11 is reserved; unless fixed channel is on it is treated like 00 so the output stays defined
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_use_i <= 1'b1;
      o_use_q <= 1'b0;
    end
    else if (fixed_channel_enable)
    begin
      o_use_i <= !channel_use_select[0];
      o_use_q <= channel_use_select[0];
    end
    else
    begin
      unique case (channel_use_select)
        RXDSC_CH_STRONGER_HOLD:
        begin
          o_use_i <= held_valid ? held_i : i_i_stronger;
          o_use_q <= held_valid ? !held_i : !i_i_stronger;
        end
        RXDSC_CH_COMBINE:
        begin
          o_use_i <= 1'b1;
          o_use_q <= 1'b1;
        end
        default:
        begin
          o_use_i <= i_i_stronger;
          o_use_q <= !i_i_stronger;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pll_tau <= 2'h0;
      o_pll_freeze <= 1'b0;
    end
    else if (i_rx_burst)
    begin
      o_pll_tau <= pll_burst_time_constant;
      o_pll_freeze <= 1'b0;
    end
    else
    begin
      o_pll_tau <= pll_receive_time_constant;
      o_pll_freeze <= i_rx_active && (pll_receive_time_constant == 2'h0);
    end
  end

  rxdsc_tick_div #(
    .PW(PW)
  ) u_tick_div (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ref_tick(i_ref_tick),
    .i_prescaler_value(prescaler_value),
    .i_even(prescaler_even_select),
    .o_tick(tick)
  );

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_timer_tick <= 1'b0;
    end
    else
    begin
      o_timer_tick <= tick;
    end
  end

  // Sync sequence: prefix zeros, then B2, then 4D; steps on each burst cycle
  assign sync_total = {1'b0, sync_prefix_length} + 3'h2;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync_pos <= 3'h0;
      o_sync_byte <= 8'h00;
    end
    else if (!i_rx_burst)
    begin
      sync_pos <= 3'h0;
      o_sync_byte <= 8'h00;
    end
    else
    begin
      sync_pos <= (sync_pos + 3'h1 >= sync_total) ? 3'h0 : sync_pos + 3'h1;
      if (sync_pos < {1'b0, sync_prefix_length})
      begin
        o_sync_byte <= 8'h00;
      end
      else if (sync_pos == {1'b0, sync_prefix_length})
      begin
        o_sync_byte <= `RXDSC_SYNC_HI;
      end
      else
      begin
        o_sync_byte <= `RXDSC_SYNC_LO;
      end
    end
  end

  // Length counter saturates so huge packets never wrap into a short one
  assign len_ok = (i_rate_106k && !i_sync_detect_enable) ||
    ({{(LW-8){1'b0}}, min_packet_length, 2'b00} <= pkt_len);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pk_state <= RXDSC_PK_IDLE;
    end
    else
    begin
      pk_state <= next_pk_state;
    end
  end

  always_comb
  begin
    next_pk_state = pk_state;
    unique case (pk_state)
      RXDSC_PK_IDLE: if (i_pkt_start) next_pk_state = RXDSC_PK_COUNT;
      RXDSC_PK_COUNT: if (i_pkt_end) next_pk_state = len_ok ? RXDSC_PK_DONE : RXDSC_PK_DROP;
      RXDSC_PK_DONE: next_pk_state = RXDSC_PK_IDLE;
      RXDSC_PK_DROP: next_pk_state = RXDSC_PK_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pkt_len <= '0;
    end
    else if (pk_state == RXDSC_PK_IDLE)
    begin
      pkt_len <= '0;
    end
    else if (pk_state == RXDSC_PK_COUNT && i_pkt_byte && !(&pkt_len))
    begin
      pkt_len <= pkt_len + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pkt_accept <= 1'b0;
      o_pkt_drop <= 1'b0;
      accepted_cnt <= 8'h00;
      dropped_cnt <= 8'h00;
    end
    else
    begin
      o_pkt_accept <= (pk_state == RXDSC_PK_COUNT) && i_pkt_end && len_ok;
      o_pkt_drop <= (pk_state == RXDSC_PK_COUNT) && i_pkt_end && !len_ok;
      if (pk_state == RXDSC_PK_DONE)
      begin
        accepted_cnt <= accepted_cnt + 8'h01;
      end
      if (pk_state == RXDSC_PK_DROP)
      begin
        dropped_cnt <= dropped_cnt + 8'h01;
      end
    end
  end
endmodule : rxdsc_top
`default_nettype wire

// *** verif/rxdsc_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rxdsc_regs.svh"
module rxdsc_props
  import rxdsc_pkg::*;
#(
  parameter int PW = 12,
  parameter int LW = 9
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_sync_detect_enable,
  input wire logic i_rate_106k,
  input wire logic i_rx_burst,
  input wire logic i_pkt_end,
  input wire logic o_use_i,
  input wire logic o_use_q,
  input wire logic o_pll_freeze,
  input wire logic [1:0] o_pll_tau,
  input wire logic [7:0] o_sync_byte,
  input wire logic o_pkt_accept,
  input wire logic o_pkt_drop
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Shadow follows completed writes only; lines up with the registered channel outputs
  logic [7:0] dm_shadow;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      dm_shadow <= `RXDSC_RST_DEMOD;
    end
    else if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] &&
             i_avs_address == `RXDSC_IDX_DEMOD)
    begin
      dm_shadow <= i_avs_writedata[7:0];
    end
  end
  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_end;
    i_pkt_end;
  endsequence
  property p_ack;
    s_req |=> !o_avs_waitrequest;
  endproperty
  property p_one;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  property p_wide;
    !o_avs_waitrequest && $past(i_avs_read) && $past(i_avs_address) == 8'h19
      |-> o_avs_readdata[31:8] == 24'h0;
  endproperty
  property p_done;
    s_end |=> o_pkt_accept ^ o_pkt_drop;
  endproperty
  property p_cause;
    (o_pkt_accept || o_pkt_drop) |-> $past(i_pkt_end);
  endproperty
  property p_byp;
    s_end ##0 (i_rate_106k && !i_sync_detect_enable) |=> o_pkt_accept;
  endproperty
  property p_frz;
    o_pll_freeze |-> o_pll_tau == 2'h0 && !$past(i_rx_burst);
  endproperty
  property p_sync;
    !$past(i_rx_burst) |-> o_sync_byte == 8'h00;
  endproperty
  property p_chan;
    !dm_shadow[5] && dm_shadow[7:6] == 2'h2 |-> o_use_i && o_use_q;
  endproperty
  property p_fix;
    dm_shadow[5] |-> o_use_i == !dm_shadow[6] && o_use_q == dm_shadow[6];
  endproperty
  a_ack: assert property (p_ack) else $error("no answer after request");
  a_one: assert property (p_one) else $error("answer held too long");
  a_wide: assert property (p_wide) else $error("unused bits not zero");
  a_done: assert property (p_done) else $error("no single verdict");
  a_cause: assert property (p_cause) else $error("verdict without end");
  a_byp: assert property (p_byp) else $error("bypass not accepted");
  a_frz: assert property (p_frz) else $error("freeze outside receive");
  a_sync: assert property (p_sync) else $error("sync byte outside burst");
  a_chan: assert property (p_chan) else $error("combine mode not on both channels");
  a_fix: assert property (p_fix) else $error("fixed channel not honoured");
endmodule : rxdsc_props
`default_nettype wire

// *** verif/rxdsc_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rxdsc_regs.svh"
module rxdsc_top_tb
  import rxdsc_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_avs_address = 8'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0] i_avs_byteenable = 4'hf;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic i_sync_detect_enable = 1'b0;
  logic i_rate_106k = 1'b0;
  logic i_ref_tick = 1'b0;
  logic i_rx_active = 1'b0;
  logic i_rx_burst = 1'b0;
  logic i_i_stronger = 1'b0;
  logic i_pkt_start = 1'b0;
  logic i_pkt_byte = 1'b0;
  logic i_pkt_end = 1'b0;
  logic o_use_i, o_use_q, o_pll_freeze, o_timer_tick, o_pkt_accept, o_pkt_drop;
  logic [1:0] o_pll_tau;
  logic [7:0] o_sync_byte;
  int error_cnt = 0;
  int n_checks = 0;
  logic [7:0] s = 8'h30;
  logic [31:0] q;
  logic [10:0] ct [6] = '{11'h102, 11'h305, 11'h502, 11'h407, 11'h001, 11'h006};
  rxdsc_top #(.PW(12), .LW(9)) rxdsc_top_inst (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_sync_detect_enable(i_sync_detect_enable),
    .i_rate_106k(i_rate_106k),
    .i_ref_tick(i_ref_tick),
    .i_rx_active(i_rx_active),
    .i_rx_burst(i_rx_burst),
    .i_i_stronger(i_i_stronger),
    .i_pkt_start(i_pkt_start),
    .i_pkt_byte(i_pkt_byte),
    .i_pkt_end(i_pkt_end),
    .o_use_i(o_use_i),
    .o_use_q(o_use_q),
    .o_pll_freeze(o_pll_freeze),
    .o_pll_tau(o_pll_tau),
    .o_timer_tick(o_timer_tick),
    .o_sync_byte(o_sync_byte),
    .o_pkt_accept(o_pkt_accept),
    .o_pkt_drop(o_pkt_drop)
  );
  always #5 i_clk = ~i_clk;
  // Reference pulse every second cycle keeps tick spacing measurable
  always @(posedge i_clk) i_ref_tick <= ~i_ref_tick;
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  // Reference pulse comes every second cycle, so each divisor step costs two cycles
  function automatic int tick_period(input int p, input int even);
    return 2 * (2 * p + 1 + even);
  endfunction : tick_period
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do
    begin
      @(posedge i_clk);
    end
    while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rchk
  task automatic pkt(input int n, input logic e);
    @(posedge i_clk);
    i_pkt_start <= 1'b1;
    repeat (n)
    begin
      @(posedge i_clk);
      i_pkt_start <= 1'b0;
      i_pkt_byte <= 1'b1;
    end
    @(posedge i_clk);
    i_pkt_start <= 1'b0;
    i_pkt_byte <= 1'b0;
    i_pkt_end <= 1'b1;
    @(posedge i_clk);
    i_pkt_end <= 1'b0;
    @(posedge i_clk);
    chk({o_pkt_accept, o_pkt_drop}, {e, !e});
    cyc(2);
  endtask : pkt
  task automatic tper(output int c);
    repeat (200)
    begin
      @(posedge i_clk);
      if (o_timer_tick === 1'b1)
        break;
    end
    c = 0;
    repeat (200)
    begin
      @(posedge i_clk);
      c++;
      if (o_timer_tick === 1'b1)
        break;
    end
  endtask : tper
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  initial
  begin
    cyc(20000);
    error_cnt++;
    summarize();
  end
  initial
  begin
    int k;
    int c;
    int m;
    logic [7:0] v;
    logic [10:0] e;
    cyc(12);
    i_rst_n <= 1'b1;
    rchk(`RXDSC_IDX_DEMOD, 32'h4d);
    rchk(`RXDSC_IDX_SYNCMIN, 32'h0);
    bus(1'b1, 8'h55, 32'hff);
    rchk(8'h55, 32'h0);
    for (k = 0; k < 8; k++)
    begin
      s = lfsr(s);
      v = (s[7:6] == 2'h3) ? {1'b0, s[6:0]} : s;
      bus(1'b1, `RXDSC_IDX_DEMOD, {24'h0, v});
      rchk(`RXDSC_IDX_DEMOD, {24'h0, v});
      bus(1'b1, `RXDSC_IDX_SYNCMIN, {24'h0, ~s});
      rchk(`RXDSC_IDX_SYNCMIN, {24'h0, ~s});
    end
    $display("test registers done");
    for (k = 0; k < 6; k++)
    begin
      e = ct[k];
      bus(1'b1, `RXDSC_IDX_DEMOD, {24'h0, e[10:3]});
      i_i_stronger <= e[2];
      cyc(3);
      chk({o_use_i, o_use_q}, e[1:0]);
    end
    bus(1'b1, `RXDSC_IDX_DEMOD, 32'h40);
    i_i_stronger <= 1'b1;
    i_rx_active <= 1'b1;
    cyc(3);
    i_i_stronger <= 1'b0;
    cyc(3);
    chk({o_use_i, o_use_q}, 2'h2);
    $display("test channels done");
    bus(1'b1, `RXDSC_IDX_DEMOD, 32'h03);
    i_rx_burst <= 1'b1;
    cyc(3);
    chk(o_pll_tau, 2'h3);
    i_rx_burst <= 1'b0;
    cyc(3);
    chk({o_pll_freeze, o_pll_tau}, 3'h4);
    bus(1'b1, `RXDSC_IDX_DEMOD, 32'h0b);
    cyc(2);
    chk({o_pll_freeze, o_pll_tau}, 3'h2);
    i_rx_active <= 1'b0;
    $display("test pll done");
    for (k = 0; k < 4; k++)
    begin
      bus(1'b1, `RXDSC_IDX_SYNCMIN, {24'h0, k[1:0], 6'h0});
      i_rx_burst <= 1'b1;
      c = 0;
      do
      begin
        @(posedge i_clk);
        c++;
      end
      while (o_sync_byte === 8'h00 && c < 60);
      chk(o_sync_byte, 8'hb2);
      chk(c, k + 2);
      @(posedge i_clk);
      chk(o_sync_byte, 8'h4d);
      i_rx_burst <= 1'b0;
      cyc(3);
    end
    $display("test sync done");
    s = lfsr(s);
    m = 1 + s[2:0];
    bus(1'b1, `RXDSC_IDX_SYNCMIN, m);
    pkt(4 * m - 1, 1'b0);
    pkt(4 * m, 1'b1);
    i_rate_106k <= 1'b1;
    pkt(1, 1'b1);
    i_sync_detect_enable <= 1'b1;
    pkt(1, 1'b0);
    i_rate_106k <= 1'b0;
    bus(1'b1, `RXDSC_IDX_SYNCMIN, 32'h0);
    pkt(0, 1'b1);
    rchk(`RXDSC_IDX_STATUS, 32'h00020301);
    $display("test packets done");
    s = lfsr(s);
    m = s[2:0];
    bus(1'b1, `RXDSC_IDX_PRESCALER, m);
    for (k = 0; k < 2; k++)
    begin
      bus(1'b1, `RXDSC_IDX_DEMOD, {27'h0, k[0], 4'h0});
      tper(c);
      tper(c);
      chk(c, tick_period(m, k));
    end
    $display("test timer done");
    summarize();
  end
endmodule : rxdsc_top_tb
bind rxdsc_top rxdsc_props #(.PW(PW), .LW(LW)) rxdsc_props_inst (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .i_sync_detect_enable(i_sync_detect_enable),
  .i_rate_106k(i_rate_106k),
  .i_rx_burst(i_rx_burst),
  .i_pkt_end(i_pkt_end),
  .o_use_i(o_use_i),
  .o_use_q(o_use_q),
  .o_pll_freeze(o_pll_freeze),
  .o_pll_tau(o_pll_tau),
  .o_sync_byte(o_sync_byte),
  .o_pkt_accept(o_pkt_accept),
  .o_pkt_drop(o_pkt_drop)
);
`default_nettype wire
